// ### hw/hbp_regs.svh
/*
 Constants of the bridge bus port: bus command codes, answer codes and wait limits.
 Assumes inclusion by bare name from any design file; holds defines only.
*/
`ifndef HBP_REGS_SVH
`define HBP_REGS_SVH

// bus command codes on the command/byte-enable lines
`define HBP_CMD_IACK 4'h0
`define HBP_CMD_SPC 4'h1
`define HBP_CMD_IORD 4'h2
`define HBP_CMD_IOWR 4'h3
`define HBP_CMD_RSV4 4'h4
`define HBP_CMD_RSV5 4'h5
`define HBP_CMD_MRD 4'h6
`define HBP_CMD_MWR 4'h7
`define HBP_CMD_RSV8 4'h8
`define HBP_CMD_RSV9 4'h9
`define HBP_CMD_CFGRD 4'hA
`define HBP_CMD_CFGWR 4'hB
`define HBP_CMD_MRM 4'hC
`define HBP_CMD_DAC 4'hD
`define HBP_CMD_MRL 4'hE
`define HBP_CMD_MWI 4'hF
// command bit that marks a write
`define HBP_CMD_WR_BIT 0

// initiator answer codes
`define HBP_ST_OK 2'h0
`define HBP_ST_MABORT 2'h1
`define HBP_ST_STOP 2'h2
`define HBP_ST_REFUSED 2'h3

// data-phase wait before master abort, and before target stop
`define HBP_DEVSEL_TMO 4'h6
`define HBP_STOP_TMO 4'h8
// byte address step between data phases of a burst
`define HBP_ADDR_STEP 32'h4

`endif

// ### hw/hbp_pkg.sv
/*
 Types of the bridge bus port: state encodings and the buffered write word.
 Assumes no imports; users write hbp_pkg::name.
*/
package hbp_pkg;

   typedef enum logic [3:0] {
      M_IDLE = 4'h1,
      M_ADDR = 4'h2,
      M_DATA = 4'h4,
      M_TURN = 4'h8
   } hbp_mst_e;

   typedef enum logic [2:0] {
      T_IDLE = 3'h1,
      T_DATA = 3'h2,
      T_TURN = 3'h4
   } hbp_tgt_e;

   typedef struct packed {
      logic [31:0] addr;
      logic [3:0] be_n;
      logic [31:0] data;
   } hbp_word_s;

endpackage : hbp_pkg

// ### hw/hbp_strm_if.sv
/*
 Valid/ready stream carrier between the bus port and its write buffer.
 Assumes one source and one sink on the same clock.
*/
`timescale 1ns/1ps
interface hbp_strm_if #(parameter int W = 68);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : hbp_strm_if

// ### hw/hbp_fifo.sv
/*
 Flip-flop FIFO with valid/ready on both sides; width and depth are parameters.
 Assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/1ps
module hbp_fifo #(
   parameter int W = 68,
   parameter int DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   hbp_strm_if.snk wr,
   hbp_strm_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = DEPTH[AW:0];
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign wr.ready = (cnt_q != FULL);
   assign rd.valid = (cnt_q != '0);
   assign rd.data = mem_q[rp_q];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wp_q] <= wr.data;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'h1;
         end
         if (pop) begin
            rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'h1;
         end
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule : hbp_fifo

// ### hw/hbp_par.sv
/*
 Even parity over a parameterised group of lines.
 Assumes purely combinational use; the caller registers the result.
*/
`timescale 1ns/1ps
module hbp_par #(
   parameter int W = 36
) (
   input wire logic [W-1:0] bits_in,
   output logic even_out
);
   assign even_out = ^bits_in;
endmodule : hbp_par

// ### hw/hbp_top.sv
/*
 Bus port of a host bridge: single-phase initiator and memory/aperture target.
 Assumes pin levels resolved outside from the *_OE_OUT enables; all bus input pins pass two flops.
*/
`timescale 1ns/1ps
`include "hbp_regs.svh"
module hbp_top #(
   parameter logic [31:0] DRAM_TOP = 32'h0800_0000,
   parameter logic [31:0] APER_BASE = 32'hE000_0000,
   parameter logic [31:0] APER_SIZE = 32'h0400_0000,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic CLK_SYS_IN,
   input wire logic NRST_IN,
   input wire logic [31:0] AD_IN,
   output logic [31:0] AD_OUT,
   output logic AD_OE_OUT,
   input wire logic [3:0] CBE_N_IN,
   output logic [3:0] CBE_N_OUT,
   output logic CBE_OE_OUT,
   input wire logic PAR_IN,
   output logic PAR_OUT,
   output logic PAR_OE_OUT,
   input wire logic FRAME_N_IN,
   output logic FRAME_N_OUT,
   output logic FRAME_OE_OUT,
   input wire logic IRDY_N_IN,
   output logic IRDY_N_OUT,
   output logic IRDY_OE_OUT,
   input wire logic TRDY_N_IN,
   output logic TRDY_N_OUT,
   input wire logic DEVSEL_N_IN,
   output logic DEVSEL_N_OUT,
   input wire logic STOP_N_IN,
   output logic STOP_N_OUT,
   output logic TCTL_OE_OUT,
   input wire logic MI_REQ_IN,
   input wire logic [3:0] MI_CMD_IN,
   input wire logic [31:0] MI_ADDR_IN,
   input wire logic [3:0] MI_BE_N_IN,
   input wire logic [31:0] MI_WDATA_IN,
   output logic MI_BUSY_OUT,
   output logic MI_DONE_OUT,
   output logic [1:0] MI_STATUS_OUT,
   output logic [31:0] MI_RDATA_OUT,
   output logic TR_RREQ_OUT,
   output logic [31:0] TR_RADDR_OUT,
   input wire logic [31:0] TR_RDATA_IN,
   input wire logic TR_RVALID_IN,
   output logic TW_VALID_OUT,
   output logic [31:0] TW_ADDR_OUT,
   output logic [3:0] TW_BE_N_OUT,
   output logic [31:0] TW_DATA_OUT,
   input wire logic TW_READY_IN,
   output logic PAR_ERR_OUT
);
   localparam int WW = $bits(hbp_pkg::hbp_word_s);

   logic [41:0] sync1_q, sync2_q;
   logic [31:0] ad_s;
   logic [3:0] cbe_n_s;
   logic par_s, frame_n_s, irdy_n_s, trdy_n_s, devsel_n_s, stop_n_s;
   logic frame_prev_q;
   logic [1:0] own_q;
   hbp_pkg::hbp_mst_e m_state_q;
   hbp_pkg::hbp_tgt_e t_state_q;
   logic [31:0] m_addr_q, m_wdata_q, t_addr_q;
   logic [3:0] m_cmd_q, m_be_q, t_cmd_q, m_cnt_q, t_wait_q;
   logic [2:0] pipe_q;
   logic t_have_q, chk_q, calc_q, par_gen, par_chk;
   logic m_rsv, bus_idle, m_start, m_xfer, m_stop, m_abort, m_end;
   logic t_start, t_hit, t_xfer, t_fin, t_pulse, t_load, t_wr;
   hbp_pkg::hbp_word_s out_w;

   hbp_strm_if #(.W(WW)) wr_if();
   hbp_strm_if #(.W(WW)) rd_if();

   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!NRST_IN);

   function automatic logic is_rsv(input logic [3:0] c);
      is_rsv = c inside {`HBP_CMD_RSV4, `HBP_CMD_RSV5, `HBP_CMD_RSV8, `HBP_CMD_RSV9, `HBP_CMD_DAC};
   endfunction : is_rsv

   function automatic logic is_mem(input logic [3:0] c);
      is_mem = c inside {`HBP_CMD_MRD, `HBP_CMD_MWR, `HBP_CMD_MRM, `HBP_CMD_MRL, `HBP_CMD_MWI};
   endfunction : is_mem

   // all bus inputs pass two flops before use
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         sync1_q <= '1;
         sync2_q <= '1;
      end else begin
         sync1_q <= {AD_IN, CBE_N_IN, PAR_IN, FRAME_N_IN, IRDY_N_IN, TRDY_N_IN, DEVSEL_N_IN, STOP_N_IN};
         sync2_q <= sync1_q;
      end
   end
   assign {ad_s, cbe_n_s, par_s, frame_n_s, irdy_n_s, trdy_n_s, devsel_n_s, stop_n_s} = sync2_q;

   // own frame delayed to line up with the synchronised copy
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         frame_prev_q <= 1'h1;
         own_q <= '0;
      end else begin
         frame_prev_q <= frame_n_s;
         own_q <= {own_q[0], FRAME_OE_OUT};
      end
   end

   // initiator
   assign m_rsv = is_rsv(MI_CMD_IN);
   assign bus_idle = frame_n_s && irdy_n_s && (t_state_q == hbp_pkg::T_IDLE) && (own_q == '0);
   assign m_start = (m_state_q == hbp_pkg::M_IDLE) && MI_REQ_IN && !MI_DONE_OUT && !m_rsv && bus_idle;
   assign m_xfer = (m_state_q == hbp_pkg::M_DATA) && !irdy_n_s && !trdy_n_s;
   assign m_stop = (m_state_q == hbp_pkg::M_DATA) && !m_xfer && !stop_n_s;
   assign m_abort = (m_state_q == hbp_pkg::M_DATA) && devsel_n_s && (m_cnt_q == `HBP_DEVSEL_TMO);
   assign m_end = m_xfer || m_stop || m_abort;

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         m_state_q <= hbp_pkg::M_IDLE;
      end else begin
         unique case (m_state_q)
            hbp_pkg::M_IDLE: if (m_start) m_state_q <= hbp_pkg::M_ADDR;
            hbp_pkg::M_ADDR: m_state_q <= hbp_pkg::M_DATA;
            hbp_pkg::M_DATA: if (m_end) m_state_q <= hbp_pkg::M_TURN;
            hbp_pkg::M_TURN: m_state_q <= hbp_pkg::M_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         m_addr_q <= '0;
         m_wdata_q <= '0;
         m_cmd_q <= '0;
         m_be_q <= '1;
         m_cnt_q <= '0;
      end else begin
         if (m_start) begin
            m_addr_q <= MI_ADDR_IN;
            m_wdata_q <= MI_WDATA_IN;
            m_cmd_q <= MI_CMD_IN;
            m_be_q <= MI_BE_N_IN;
         end
         if (m_state_q == hbp_pkg::M_ADDR) begin
            m_cnt_q <= '0;
         end else if ((m_state_q == hbp_pkg::M_DATA) && (m_cnt_q != `HBP_DEVSEL_TMO)) begin
            m_cnt_q <= m_cnt_q + 4'h1;
         end
      end
   end

   // frame, initiator ready and command/enables
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         FRAME_N_OUT <= 1'h1;
         FRAME_OE_OUT <= 1'h0;
         IRDY_N_OUT <= 1'h1;
         IRDY_OE_OUT <= 1'h0;
         CBE_N_OUT <= '1;
         CBE_OE_OUT <= 1'h0;
      end else begin
         unique case (m_state_q)
            hbp_pkg::M_IDLE: if (m_start) begin
               FRAME_N_OUT <= 1'h0;
               FRAME_OE_OUT <= 1'h1;
               IRDY_N_OUT <= 1'h1;
               IRDY_OE_OUT <= 1'h1;
               CBE_N_OUT <= MI_CMD_IN;
               CBE_OE_OUT <= 1'h1;
            end
            hbp_pkg::M_ADDR: begin
               FRAME_N_OUT <= 1'h1;
               IRDY_N_OUT <= 1'h0;
               CBE_N_OUT <= m_be_q;
            end
            hbp_pkg::M_DATA: if (m_end) begin
               IRDY_N_OUT <= 1'h1;
               CBE_OE_OUT <= 1'h0;
            end
            hbp_pkg::M_TURN: begin
               FRAME_OE_OUT <= 1'h0;
               IRDY_OE_OUT <= 1'h0;
            end
         endcase
      end
   end

   // answers to the local initiator user
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         MI_DONE_OUT <= 1'h0;
         MI_STATUS_OUT <= `HBP_ST_OK;
         MI_RDATA_OUT <= '0;
         MI_BUSY_OUT <= 1'h0;
      end else begin
         MI_BUSY_OUT <= m_start || (m_state_q == hbp_pkg::M_ADDR) || (m_state_q == hbp_pkg::M_DATA);
         MI_DONE_OUT <= m_end || ((m_state_q == hbp_pkg::M_IDLE) && MI_REQ_IN && !MI_DONE_OUT && m_rsv);
         if ((m_state_q == hbp_pkg::M_IDLE) && MI_REQ_IN && !MI_DONE_OUT && m_rsv) begin
            MI_STATUS_OUT <= `HBP_ST_REFUSED;
         end else if (m_xfer) begin
            MI_STATUS_OUT <= `HBP_ST_OK;
         end else if (m_stop) begin
            MI_STATUS_OUT <= `HBP_ST_STOP;
         end else if (m_abort) begin
            MI_STATUS_OUT <= `HBP_ST_MABORT;
         end
         if (m_xfer && !m_cmd_q[`HBP_CMD_WR_BIT]) begin
            MI_RDATA_OUT <= ad_s;
         end
      end
   end

   // target
   assign t_hit = is_mem(cbe_n_s) && ((ad_s < DRAM_TOP) ||
                  ((ad_s >= APER_BASE) && ((ad_s - APER_BASE) < APER_SIZE)));
   assign t_start = (t_state_q == hbp_pkg::T_IDLE) && (m_state_q == hbp_pkg::M_IDLE) &&
                    !frame_n_s && frame_prev_q && (own_q == '0);
   assign t_wr = t_cmd_q[`HBP_CMD_WR_BIT];
   assign t_xfer = (t_state_q == hbp_pkg::T_DATA) && pipe_q[2] && !irdy_n_s && !trdy_n_s;
   assign t_fin = (t_state_q == hbp_pkg::T_DATA) && frame_n_s && (t_xfer || !STOP_N_OUT);
   assign t_pulse = (t_state_q == hbp_pkg::T_DATA) && (pipe_q == '0) && TRDY_N_OUT && STOP_N_OUT &&
                    (t_wr ? wr_if.ready : t_have_q);
   assign t_load = (t_state_q == hbp_pkg::T_DATA) && !t_wr && !t_have_q && TR_RVALID_IN;

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         t_state_q <= hbp_pkg::T_IDLE;
      end else begin
         unique case (t_state_q)
            hbp_pkg::T_IDLE: if (t_start && t_hit) t_state_q <= hbp_pkg::T_DATA;
            hbp_pkg::T_DATA: if (t_fin) t_state_q <= hbp_pkg::T_TURN;
            hbp_pkg::T_TURN: t_state_q <= hbp_pkg::T_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         t_addr_q <= '0;
         t_cmd_q <= '0;
         t_have_q <= 1'h0;
         TR_RREQ_OUT <= 1'h0;
      end else begin
         if (t_start) begin
            t_addr_q <= ad_s;
            t_cmd_q <= cbe_n_s;
         end else if (t_xfer) begin
            t_addr_q <= t_addr_q + `HBP_ADDR_STEP;
         end
         TR_RREQ_OUT <= (t_start && t_hit && !cbe_n_s[`HBP_CMD_WR_BIT]) || (t_xfer && !t_wr && !frame_n_s);
         if (t_load) begin
            t_have_q <= 1'h1;
         end else if (t_xfer || (t_state_q != hbp_pkg::T_DATA)) begin
            t_have_q <= 1'h0;
         end
      end
   end
   assign TR_RADDR_OUT = t_addr_q;

   // device select, one-cycle target ready pulses, stop
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         DEVSEL_N_OUT <= 1'h1;
         TRDY_N_OUT <= 1'h1;
         STOP_N_OUT <= 1'h1;
         TCTL_OE_OUT <= 1'h0;
         pipe_q <= '0;
         t_wait_q <= '0;
      end else begin
         pipe_q <= {pipe_q[1:0], t_pulse};
         unique case (t_state_q)
            hbp_pkg::T_IDLE: begin
               t_wait_q <= '0;
               if (t_start && t_hit) begin
                  DEVSEL_N_OUT <= 1'h0;
                  TCTL_OE_OUT <= 1'h1;
               end
            end
            hbp_pkg::T_DATA: begin
               TRDY_N_OUT <= !t_pulse || t_fin;
               if (t_pulse || t_xfer) begin
                  t_wait_q <= '0;
               end else if (t_wait_q != `HBP_STOP_TMO) begin
                  t_wait_q <= t_wait_q + 4'h1;
               end
               if (t_wait_q == `HBP_STOP_TMO) begin
                  STOP_N_OUT <= 1'h0;
               end
               if (t_fin) begin
                  DEVSEL_N_OUT <= 1'h1;
                  STOP_N_OUT <= 1'h1;
               end
            end
            hbp_pkg::T_TURN: TCTL_OE_OUT <= 1'h0;
         endcase
      end
   end

   // address/data lines shared by both roles
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         AD_OUT <= '0;
         AD_OE_OUT <= 1'h0;
      end else if (m_start) begin
         AD_OUT <= MI_ADDR_IN;
         AD_OE_OUT <= 1'h1;
      end else if (m_state_q == hbp_pkg::M_ADDR) begin
         AD_OUT <= m_wdata_q;
         AD_OE_OUT <= m_cmd_q[`HBP_CMD_WR_BIT];
      end else if (m_end || (t_state_q == hbp_pkg::T_TURN) || t_fin) begin
         AD_OE_OUT <= 1'h0;
      end else if (t_load) begin
         AD_OUT <= TR_RDATA_IN;
         AD_OE_OUT <= 1'h1;
      end
   end

   hbp_par #(.W(36)) u_par_gen (
      .bits_in({AD_OUT, CBE_OE_OUT ? CBE_N_OUT : cbe_n_s}),
      .even_out(par_gen)
   );
   hbp_par #(.W(36)) u_par_chk (
      .bits_in({ad_s, cbe_n_s}),
      .even_out(par_chk)
   );

   // parity one clock behind the lines it covers; check on buffered writes
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         PAR_OUT <= 1'h0;
         PAR_OE_OUT <= 1'h0;
         chk_q <= 1'h0;
         calc_q <= 1'h0;
         PAR_ERR_OUT <= 1'h0;
      end else begin
         PAR_OUT <= par_gen;
         PAR_OE_OUT <= AD_OE_OUT;
         chk_q <= t_xfer && t_wr;
         calc_q <= par_chk;
         PAR_ERR_OUT <= chk_q && (par_s != calc_q);
      end
   end

   // write words: bus -> fifo -> output register
   assign wr_if.valid = t_xfer && t_wr;
   assign wr_if.data = {t_addr_q, cbe_n_s, ad_s};
   assign rd_if.ready = !TW_VALID_OUT || TW_READY_IN;
   assign out_w = rd_if.data;

   hbp_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(CLK_SYS_IN),
      .nrst_in(NRST_IN),
      .wr(wr_if),
      .rd(rd_if)
   );

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         TW_VALID_OUT <= 1'h0;
         TW_ADDR_OUT <= '0;
         TW_BE_N_OUT <= '1;
         TW_DATA_OUT <= '0;
      end else if (rd_if.ready) begin
         TW_VALID_OUT <= rd_if.valid;
         if (rd_if.valid) begin
            TW_ADDR_OUT <= out_w.addr;
            TW_BE_N_OUT <= out_w.be_n;
            TW_DATA_OUT <= out_w.data;
         end
      end
   end

   property p_addr_phase;
      m_start |=> AD_OE_OUT && (AD_OUT == $past(MI_ADDR_IN)) && !FRAME_N_OUT;
   endproperty
   a_addr_phase: assert property (p_addr_phase) else $error("address not driven with frame");
   property p_tgt_latch;
      t_start |=> (t_addr_q == $past(ad_s)) && (t_cmd_q == $past(cbe_n_s));
   endproperty
   a_tgt_latch: assert property (p_tgt_latch) else $error("target did not latch address phase");
   property p_claim;
      $fell(DEVSEL_N_OUT) |-> $past(t_start && t_hit);
   endproperty
   a_claim: assert property (p_claim) else $error("device select without range hit");
   property p_abort;
      $rose(MI_DONE_OUT) && (MI_STATUS_OUT == `HBP_ST_MABORT) |-> $past(devsel_n_s, 1);
   endproperty
   a_abort: assert property (p_abort) else $error("master abort while claimed");
   property p_last_phase;
      (m_state_q == hbp_pkg::M_ADDR) |=> FRAME_N_OUT && FRAME_OE_OUT && !IRDY_N_OUT;
   endproperty
   a_last_phase: assert property (p_last_phase) else $error("final phase without frame release");
   property p_irdy;
      !IRDY_N_OUT |-> (m_state_q == hbp_pkg::M_DATA) && IRDY_OE_OUT;
   endproperty
   a_irdy: assert property (p_irdy) else $error("initiator ready outside data phase");
   property p_cbe;
      (m_state_q == hbp_pkg::M_ADDR) |-> (CBE_N_OUT == m_cmd_q) ##1 (CBE_N_OUT == m_be_q);
   endproperty
   a_cbe: assert property (p_cbe) else $error("command or enables misplaced");
   property p_refuse;
      (m_state_q == hbp_pkg::M_IDLE) && MI_REQ_IN && !MI_DONE_OUT && m_rsv
         |=> MI_DONE_OUT && (MI_STATUS_OUT == `HBP_ST_REFUSED) && !FRAME_OE_OUT;
   endproperty
   a_refuse: assert property (p_refuse) else $error("reserved command not refused");
   property p_parity;
      AD_OE_OUT |=> PAR_OE_OUT && !(^{PAR_OUT, $past(AD_OUT), $past(CBE_OE_OUT ? CBE_N_OUT : cbe_n_s)});
   endproperty
   a_parity: assert property (p_parity) else $error("parity not even");
   property p_trdy_pulse;
      !TRDY_N_OUT |-> !DEVSEL_N_OUT ##1 TRDY_N_OUT [*3];
   endproperty
   a_trdy_pulse: assert property (p_trdy_pulse) else $error("target ready not a lone pulse");
   property p_stop;
      !STOP_N_OUT |-> (t_state_q == hbp_pkg::T_DATA) && TCTL_OE_OUT && $past(t_wait_q == `HBP_STOP_TMO);
   endproperty
   a_stop: assert property (p_stop) else $error("stop outside a stalled claim");
   property p_push;
      wr_if.valid |-> !irdy_n_s && !trdy_n_s && pipe_q[2] && wr_if.ready;
   endproperty
   a_push: assert property (p_push) else $error("word buffered without both readies");

   c_mst_ok: cover property (m_xfer);
   c_tgt_wr: cover property (wr_if.valid);
   c_tgt_rd: cover property (t_xfer && !t_wr);
   c_tgt_stop: cover property ($fell(STOP_N_OUT));
endmodule : hbp_top

// ### verif/hbp_agent.sv
/*
 Far-side bus target model: claims frames whose address nibble is 1, answers after wait_in clocks.
 Assumes resolved bus levels at its inputs and pull-ups on released control lines.
*/
`timescale 1ns/1ps
module hbp_agent (
   input wire logic clk_in,
   input wire logic [3:0] wait_in,
   input wire logic frame_n_in,
   input wire logic irdy_n_in,
   input wire logic [31:0] ad_in,
   input wire logic [3:0] cbe_n_in,
   output logic oe_out = 1'b0,
   output logic trdy_n_out = 1'b1,
   output logic ad_oe_out,
   output logic [31:0] ad_out
);
   logic [3:0] cnt_q, cmd_q;
   logic [31:0] addr_q, data_q;
   assign ad_oe_out = !trdy_n_out && !cmd_q[0];
   assign ad_out = ~addr_q;
   always @(posedge clk_in) begin
      trdy_n_out <= 1'b1;
      cnt_q <= cnt_q + 4'h1;
      if (!oe_out && !frame_n_in && ad_in[31:28] == 4'h1) begin
         oe_out <= 1'b1;
         cnt_q <= 4'h0;
         addr_q <= ad_in;
         cmd_q <= cbe_n_in;
      end else if (oe_out && !trdy_n_out) begin
         oe_out <= irdy_n_in;
         data_q <= ad_in;
      end else if (oe_out && frame_n_in && !irdy_n_in && cnt_q >= wait_in) begin
         trdy_n_out <= 1'b0;
      end
   end
endmodule : hbp_agent

// ### verif/test_hbp_top.sv
/*
 Bench of the bus port: initiator traffic against the target model, then bench-driven target reads and writes.
 Assumes pins resolved here from the enables; released control lines read high.
*/
`timescale 1ns/1ps
`include "hbp_regs.svh"
module test_hbp_top;
   logic CLK_SYS_IN = 1'b0, NRST_IN = 1'b0, MI_REQ_IN = 1'b0, TW_READY_IN = 1'b0, b_frame = 1'b1, b_irdy = 1'b1;
   logic b_adoe = 1'b0, a_oe, a_trdy, a_adoe;
   logic [3:0] MI_CMD_IN = 4'h0, MI_BE_N_IN = 4'h0, a_wait = 4'h0, CBE_N_OUT, TW_BE_N_OUT, b_cmd = 4'h0;
   logic [31:0] MI_ADDR_IN = 32'h0, b_ad = 32'h0, last_ad = 32'h0, a_ad, AD_OUT, TR_RADDR_OUT;
   logic [31:0] TW_ADDR_OUT, TW_DATA_OUT, MI_RDATA_OUT, t_rd;
   logic [1:0] MI_STATUS_OUT, t_par;
   logic AD_OE_OUT, CBE_OE_OUT, PAR_OUT, PAR_OE_OUT, FRAME_N_OUT, FRAME_OE_OUT, IRDY_N_OUT, IRDY_OE_OUT;
   logic TRDY_N_OUT, DEVSEL_N_OUT, STOP_N_OUT, TCTL_OE_OUT, MI_BUSY_OUT, MI_DONE_OUT, TR_RREQ_OUT, TW_VALID_OUT;
   logic PAR_ERR_OUT, mi_busy;
   int miscompares = 0, tests_run = 0, r, perrs = 0;
   logic [31:0] TR_RDATA_IN = 32'h0;
   logic TR_RVALID_IN = 1'b0;
   wire [31:0] MI_WDATA_IN = ~MI_ADDR_IN;
   wire [3:0] b_cbe = b_frame ? 4'h0 : b_cmd;
   wire FRAME_N_IN = FRAME_OE_OUT ? FRAME_N_OUT : b_frame;
   wire IRDY_N_IN = IRDY_OE_OUT ? IRDY_N_OUT : b_irdy;
   wire TRDY_N_IN = TCTL_OE_OUT ? TRDY_N_OUT : !a_oe || a_trdy;
   wire DEVSEL_N_IN = TCTL_OE_OUT ? DEVSEL_N_OUT : !a_oe;
   wire STOP_N_IN = TCTL_OE_OUT ? STOP_N_OUT : 1'b1;
   wire [3:0] CBE_N_IN = CBE_OE_OUT ? CBE_N_OUT : (b_adoe || !b_irdy) ? b_cbe : 4'hF;
   wire [31:0] AD_IN = AD_OE_OUT ? AD_OUT : a_adoe ? a_ad : b_adoe ? b_ad : ~last_ad;
   wire PAR_IN = PAR_OE_OUT ? PAR_OUT : ^{b_ad, b_cbe};
   hbp_top u_dut (.*);
   hbp_agent u_agent (.clk_in(CLK_SYS_IN), .wait_in(a_wait), .frame_n_in(FRAME_N_IN), .irdy_n_in(IRDY_N_IN),
      .ad_in(AD_IN), .cbe_n_in(CBE_N_IN), .oe_out(a_oe), .trdy_n_out(a_trdy), .ad_oe_out(a_adoe), .ad_out(a_ad));
   initial forever #2.5 CLK_SYS_IN = ~CLK_SYS_IN;
   always @(posedge CLK_SYS_IN) last_ad <= AD_IN;
   // read-data source for target reads; parity error pulses counted
   always @(negedge CLK_SYS_IN) begin
      TR_RVALID_IN <= TR_RREQ_OUT;
      TR_RDATA_IN <= ~TR_RADDR_OUT;
      if (PAR_ERR_OUT === 1'b1) perrs++;
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic mi(input logic [3:0] c, input logic [31:0] a);
      int n;
      @(negedge CLK_SYS_IN);
      mi_busy = 1'b0;
      MI_REQ_IN = 1'b1;
      MI_CMD_IN = c;
      MI_ADDR_IN = a;
      for (n = 0; n < 80 && MI_DONE_OUT !== 1'b1; n++) begin
         @(posedge CLK_SYS_IN);
         #1;
         mi_busy = mi_busy | (MI_BUSY_OUT === 1'b1);
      end
      chk("done", 32'h1, MI_DONE_OUT);
      @(negedge CLK_SYS_IN);
      MI_REQ_IN = 1'b0;
   endtask : mi
   task automatic tw(input logic [3:0] c, input logic [31:0] a, d);
      int n;
      @(negedge CLK_SYS_IN);
      b_cmd = c;
      b_frame = 1'b0;
      b_adoe = 1'b1;
      b_ad = a;
      @(negedge CLK_SYS_IN);
      b_frame = 1'b1;
      b_irdy = 1'b0;
      b_adoe = c[`HBP_CMD_WR_BIT];
      b_ad = d;
      for (n = 0, r = 0; n < 40 && r == 0; n++) begin
         @(negedge CLK_SYS_IN);
         r = TCTL_OE_OUT !== 1'b1 ? 0 : TRDY_N_OUT === 1'b0 ? 1 : STOP_N_OUT === 1'b0 ? 2 : 0;
      end
      t_rd = AD_IN;
      // hold ready through the edge that samples the target's answer
      @(negedge CLK_SYS_IN);
      t_par = {PAR_OE_OUT, PAR_OUT};
      b_irdy = 1'b1;
      b_adoe = 1'b0;
      repeat (8) @(negedge CLK_SYS_IN);
   endtask : tw
   task automatic s_init;
      logic [3:0] cm [9] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
      logic [31:0] a;
      foreach (cm[i]) begin
         a = {24'h100000, 4'(i), 4'h0};
         a_wait = 4'(i);
         mi(cm[i], a);
         chk("status", `HBP_ST_OK, MI_STATUS_OUT);
         chk("busy", 32'h1, mi_busy);
         chk("addr", a, u_agent.addr_q);
         chk("cmd", cm[i], u_agent.cmd_q);
         if (cm[i][`HBP_CMD_WR_BIT]) chk("wdata", ~a, u_agent.data_q);
         else chk("rdata", ~a, MI_RDATA_OUT);
      end
   endtask : s_init
   task automatic s_refuse;
      logic [3:0] cm [5] = '{4'h4, 4'h5, 4'h8, 4'h9, 4'hD};
      foreach (cm[i]) begin
         mi(cm[i], 32'h1000_0F00);
         chk("refused", `HBP_ST_REFUSED, MI_STATUS_OUT);
         chk("busy", 32'h0, mi_busy);
         chk("no claim", 32'h1000_0080, u_agent.addr_q);
      end
      mi(`HBP_CMD_MWR, 32'h3000_0000);
      chk("abort", `HBP_ST_MABORT, MI_STATUS_OUT);
   endtask : s_refuse
   task automatic s_tgt;
      int n;
      tw(`HBP_CMD_MWR, 32'h2000_0000, 32'h0);
      chk("claim", 32'h0, r);
      tw(`HBP_CMD_MRD, 32'h0000_2000, 32'h0);
      chk("rd_answer", 32'h1, r);
      chk("t_rdata", 32'hFFFF_DFFF, t_rd);
      chk("t_par", 32'h3, t_par);
      // eight buffered words plus the output register hold nine; the tenth is stopped
      for (int k = 0; k < 10; k++) begin
         tw(`HBP_CMD_MWR, k ? 32'h1000 + 32'(k * 4) : 32'hE000_0100, 32'hC0DE_0000 + 32'(k));
         chk("answer", k < 9 ? 32'h1 : 32'h2, r);
      end
      for (int k = 0; k < 9; k++) begin
         n = 0;
         while (TW_VALID_OUT !== 1'b1 && n++ < 20) @(negedge CLK_SYS_IN);
         chk("tw_addr", k ? 32'h1000 + 32'(k * 4) : 32'hE000_0100, TW_ADDR_OUT);
         chk("tw_data", 32'hC0DE_0000 + 32'(k), TW_DATA_OUT);
         chk("tw_be", 32'h0, TW_BE_N_OUT);
         TW_READY_IN = 1'b1;
         @(negedge CLK_SYS_IN);
      end
      chk("par_err", 32'h0, perrs);
   endtask : s_tgt
   task automatic give_verdict;
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20) @(negedge CLK_SYS_IN);
      NRST_IN = 1'b1;
      s_init;
      s_refuse;
      s_tgt;
      give_verdict;
   end
   initial begin
      #100000;
      miscompares++;
      give_verdict;
   end
endmodule : test_hbp_top
